/* common/mevd_pkg.sv */
// ----------------------------------------
// motion event detector constants
// ----------------------------------------
package mevd_pkg;
  // timing: the millisecond base is derived from the mclk period
  localparam int MCLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [11:0] HOLD_STEP_MS = 12'h200;
  // register indices (byte address is four times the index)
  localparam logic [5:0] A_RO_LAST = 6'h0E;
  localparam logic [5:0] A_STATUS = 6'h09;
  localparam logic [5:0] A_EVENT = 6'h0C;
  localparam logic [5:0] A_RANGE = 6'h0F;
  localparam logic [5:0] A_SOFTRST = 6'h14;
  localparam logic [5:0] A_INTEN0 = 6'h16;
  localparam logic [5:0] A_INTEN1 = 6'h17;
  localparam logic [5:0] A_INTCTL = 6'h21;
  localparam logic [5:0] A_FF_DUR = 6'h22;
  localparam logic [5:0] A_FF_THR = 6'h23;
  localparam logic [5:0] A_HYST = 6'h24;
  localparam logic [5:0] A_SH_DUR = 6'h25;
  localparam logic [5:0] A_SH_THR = 6'h26;
  localparam logic [5:0] A_TILT = 6'h2D;
  localparam logic [5:0] A_FLAT_TH = 6'h2E;
  localparam logic [5:0] A_FLAT_HOLD = 6'h2F;
  // field positions
  localparam int FLAT_EN_BIT = 7;
  localparam int FF_EN_BIT = 3;
  localparam int FF_MODE_BIT = 2;
  localparam int RST_INT_BIT = 7;
  localparam int FLAT_HOLD_LSB = 4;
  // scaling: 7.81 mg and 125 mg expressed in 2g-range counts
  localparam int THR_SHIFT = 1;
  localparam int HY_SHIFT = 5;
  localparam int FLAT_DIV = 8;
  localparam int FLAT_DIV_SQ = FLAT_DIV * FLAT_DIV;
  localparam logic [7:0] CFG_RESET = 8'h00;
endpackage

/* core/mevd_top.sv */
`timescale 1ns/1ps
module mevd_top #(
  parameter int MS_CYCLES = mevd_pkg::MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sample_valid,
  input wire logic [9:0] acc_x,
  input wire logic [9:0] acc_y,
  input wire logic [9:0] acc_z
);
  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic [7:0] rd_next;
  logic wr_go;
  logic rst_int_go;
  logic [7:0] inten0_reg;
  logic [3:0] inten1_reg;
  logic [7:0] ff_dur_reg;
  logic [7:0] ff_thr_reg;
  logic [7:0] hyst_reg;
  logic [7:0] sh_dur_reg;
  logic [7:0] sh_thr_reg;
  logic [5:0] tilt_reg;
  logic [5:0] flat_th_reg;
  logic [1:0] flat_hold_reg;
  logic [1:0] range_reg;
  logic latch_reg;
  logic flat_int_reg;
  logic flat_state_reg;
  logic ff_int_reg;
  logic shock_int_reg;
  logic [2:0] first_reg;
  logic sign_reg;

  // one wait state: request seen, answered on the following edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata = readdata_reg;
  // writes below 0x0F never reach storage
  assign wr_go = avs_write & ack_reg & avs_byteenable[0] & (avs_address > mevd_pkg::A_RO_LAST);
  assign rst_int_go = wr_go & (avs_address == mevd_pkg::A_INTCTL)
    & avs_writedata[mevd_pkg::RST_INT_BIT];

  // configuration store; only defined bits are kept
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inten0_reg <= mevd_pkg::CFG_RESET;
      inten1_reg <= 4'h0;
      ff_dur_reg <= mevd_pkg::CFG_RESET;
      ff_thr_reg <= mevd_pkg::CFG_RESET;
      hyst_reg <= mevd_pkg::CFG_RESET;
      sh_dur_reg <= mevd_pkg::CFG_RESET;
      sh_thr_reg <= mevd_pkg::CFG_RESET;
      tilt_reg <= 6'h00;
      flat_th_reg <= 6'h00;
      flat_hold_reg <= 2'h0;
      range_reg <= 2'h0;
      latch_reg <= 1'b0;
    end
    else if (wr_go && avs_address == mevd_pkg::A_SOFTRST)
    begin
      // soft reset restores every setting
      inten0_reg <= mevd_pkg::CFG_RESET;
      inten1_reg <= 4'h0;
      ff_dur_reg <= mevd_pkg::CFG_RESET;
      ff_thr_reg <= mevd_pkg::CFG_RESET;
      hyst_reg <= mevd_pkg::CFG_RESET;
      sh_dur_reg <= mevd_pkg::CFG_RESET;
      sh_thr_reg <= mevd_pkg::CFG_RESET;
      tilt_reg <= 6'h00;
      flat_th_reg <= 6'h00;
      flat_hold_reg <= 2'h0;
      range_reg <= 2'h0;
      latch_reg <= 1'b0;
    end
    else if (wr_go)
    begin
      case (avs_address)
        mevd_pkg::A_RANGE: range_reg <= avs_writedata[1:0];
        mevd_pkg::A_INTEN0: inten0_reg <= avs_writedata[7:0] & 8'h80;
        mevd_pkg::A_INTEN1: inten1_reg <= avs_writedata[3:0];
        mevd_pkg::A_INTCTL: latch_reg <= avs_writedata[0];
        mevd_pkg::A_FF_DUR: ff_dur_reg <= avs_writedata[7:0];
        mevd_pkg::A_FF_THR: ff_thr_reg <= avs_writedata[7:0];
        mevd_pkg::A_HYST: hyst_reg <= avs_writedata[7:0] & 8'hC7;
        mevd_pkg::A_SH_DUR: sh_dur_reg <= avs_writedata[7:0];
        mevd_pkg::A_SH_THR: sh_thr_reg <= avs_writedata[7:0];
        mevd_pkg::A_TILT: tilt_reg <= avs_writedata[5:0];
        mevd_pkg::A_FLAT_TH: flat_th_reg <= avs_writedata[5:0];
        mevd_pkg::A_FLAT_HOLD: flat_hold_reg <= avs_writedata[5:4];
        default: ;
      endcase
    end
  end

  // read mux; action bits and unmapped words read zero
  always_comb
  begin
    case (avs_address)
      mevd_pkg::A_STATUS: rd_next = {flat_int_reg, 5'h00, shock_int_reg, ff_int_reg};
      mevd_pkg::A_EVENT: rd_next = {flat_state_reg, 3'h0, sign_reg, first_reg};
      mevd_pkg::A_RANGE: rd_next = {6'h00, range_reg};
      mevd_pkg::A_INTEN0: rd_next = inten0_reg;
      mevd_pkg::A_INTEN1: rd_next = {4'h0, inten1_reg};
      mevd_pkg::A_INTCTL: rd_next = {7'h00, latch_reg};
      mevd_pkg::A_FF_DUR: rd_next = ff_dur_reg;
      mevd_pkg::A_FF_THR: rd_next = ff_thr_reg;
      mevd_pkg::A_HYST: rd_next = hyst_reg;
      mevd_pkg::A_SH_DUR: rd_next = sh_dur_reg;
      mevd_pkg::A_SH_THR: rd_next = sh_thr_reg;
      mevd_pkg::A_TILT: rd_next = {2'h0, tilt_reg};
      mevd_pkg::A_FLAT_TH: rd_next = {2'h0, flat_th_reg};
      mevd_pkg::A_FLAT_HOLD: rd_next = {2'h0, flat_hold_reg, 4'h0};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      readdata_reg <= 32'h00000000;
    else if (avs_read && !ack_reg)
      readdata_reg <= {24'h000000, rd_next};
  end

  // ----------------------------------------
  // millisecond time base
  // ----------------------------------------
  logic [15:0] ms_cnt_reg;
  logic ms_tick;

  assign ms_tick = (ms_cnt_reg == 16'(MS_CYCLES - 1));
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ms_cnt_reg <= 16'h0000;
    else if (ms_tick)
      ms_cnt_reg <= 16'h0000;
    else
      ms_cnt_reg <= ms_cnt_reg + 16'h0001;
  end

  // ----------------------------------------
  // magnitudes
  // ----------------------------------------
  function automatic logic [9:0] mevd_abs(input logic [9:0] v);
    return v[9] ? 10'(-v) : v;
  endfunction

  logic [9:0] mag [3];
  logic [12:0] mg [3];
  logic [14:0] mg_sum;
  assign mag[0] = mevd_abs(acc_x);
  assign mag[1] = mevd_abs(acc_y);
  assign mag[2] = mevd_abs(acc_z);
  // free-fall works in 2g-range counts, so coarse ranges shift up
  assign mg[0] = 13'(mag[0]) << range_reg;
  assign mg[1] = 13'(mag[1]) << range_reg;
  assign mg[2] = 13'(mag[2]) << range_reg;
  assign mg_sum = 15'(mg[0]) + 15'(mg[1]) + 15'(mg[2]);

  // ----------------------------------------
  // flat detector
  // ----------------------------------------
  logic [26:0] flat_lhs;
  logic [26:0] flat_rhs;
  logic flat_now;
  logic flat_cand_reg;
  logic [11:0] flat_ms_reg;
  logic [11:0] flat_target;
  logic flat_gen;

  // squares avoid a square root: (x^2+y^2)*64 < theta*z^2
  assign flat_lhs = (27'(mag[0]) * 27'(mag[0]) + 27'(mag[1]) * 27'(mag[1]))
    * 27'(mevd_pkg::FLAT_DIV_SQ);
  assign flat_rhs = 27'(flat_th_reg) * 27'(mag[2]) * 27'(mag[2]);
  assign flat_now = flat_lhs < flat_rhs;

  // settle time is not linear in the select code
  always_comb
  begin
    case (flat_hold_reg)
      2'h1: flat_target = mevd_pkg::HOLD_STEP_MS;
      2'h2: flat_target = 12'(mevd_pkg::HOLD_STEP_MS << 1);
      2'h3: flat_target = 12'(mevd_pkg::HOLD_STEP_MS << 2);
      default: flat_target = 12'h000;
    endcase
  end

  // stable time restarts whenever the candidate value flips
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flat_cand_reg <= 1'b0;
      flat_ms_reg <= 12'h000;
    end
    else if (sample_valid && flat_now != flat_cand_reg)
    begin
      flat_cand_reg <= flat_now;
      flat_ms_reg <= 12'h000;
    end
    else if (ms_tick && flat_ms_reg != 12'hFFF)
      flat_ms_reg <= flat_ms_reg + 12'h001;
  end

  // no new event while one persists, which freezes the state bit
  assign flat_gen = sample_valid & inten0_reg[mevd_pkg::FLAT_EN_BIT] & ~flat_int_reg
    & (flat_now != flat_state_reg)
    & ((flat_hold_reg == 2'h0)
    | ((flat_now == flat_cand_reg) & (flat_ms_reg >= flat_target)));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flat_int_reg <= 1'b0;
      flat_state_reg <= 1'b0;
    end
    else
    begin
      // non-latched: gone one sample later; latched: until reset_int
      if ((sample_valid && !latch_reg) || rst_int_go)
        flat_int_reg <= 1'b0;
      if (flat_gen)
      begin
        flat_int_reg <= 1'b1;
        flat_state_reg <= flat_now;
      end
    end
  end

  // ----------------------------------------
  // free-fall detector
  // ----------------------------------------
  logic [14:0] ff_thr;
  logic [14:0] ff_rel;
  logic ff_below;
  logic ff_above;
  logic ff_cond_reg;
  logic [10:0] ff_ms_reg;
  logic [10:0] ff_target;
  logic ff_gen;

  assign ff_thr = 15'(ff_thr_reg) << mevd_pkg::THR_SHIFT;
  assign ff_rel = ff_thr + (15'(hyst_reg[1:0]) << mevd_pkg::HY_SHIFT);
  assign ff_below = hyst_reg[mevd_pkg::FF_MODE_BIT] ? (mg_sum < ff_thr)
    : ((15'(mg[0]) < ff_thr) & (15'(mg[1]) < ff_thr) & (15'(mg[2]) < ff_thr));
  assign ff_above = hyst_reg[mevd_pkg::FF_MODE_BIT] ? (mg_sum > ff_rel)
    : ((15'(mg[0]) > ff_rel) | (15'(mg[1]) > ff_rel) | (15'(mg[2]) > ff_rel));
  assign ff_target = 11'((11'(ff_dur_reg) + 11'h001) << 1);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ff_cond_reg <= 1'b0;
      ff_ms_reg <= 11'h000;
    end
    else
    begin
      if (sample_valid)
        ff_cond_reg <= ff_below;
      // a tick landing on a sample edge still counts
      if (sample_valid && !ff_below)
        ff_ms_reg <= 11'h000;
      else if (ms_tick && ff_cond_reg && ff_ms_reg != 11'h7FF)
        ff_ms_reg <= ff_ms_reg + 11'h001;
    end
  end

  assign ff_gen = sample_valid & inten1_reg[mevd_pkg::FF_EN_BIT] & ~ff_int_reg
    & ff_below & (ff_ms_reg >= ff_target);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ff_int_reg <= 1'b0;
    else if (ff_gen)
      ff_int_reg <= 1'b1;
    else if ((sample_valid && !latch_reg && ff_above) || rst_int_go)
      ff_int_reg <= 1'b0;
  end

  // ----------------------------------------
  // shock detector
  // ----------------------------------------
  logic [10:0] sh_thr;
  logic [10:0] sh_hy;
  logic [2:0] sh_over;
  logic sh_under;
  logic sh_cond_reg;
  logic rel_cond_reg;
  logic [10:0] sh_ms_reg;
  logic [10:0] rel_ms_reg;
  logic [10:0] sh_target;
  logic [2:0] sh_first;
  logic sh_gen;
  logic sh_drop;

  // raw counts already carry the range, so no shift here
  assign sh_thr = 11'(sh_thr_reg) << mevd_pkg::THR_SHIFT;
  assign sh_hy = 11'(hyst_reg[7:6]) << mevd_pkg::HY_SHIFT;
  assign sh_target = 11'((11'(sh_dur_reg) + 11'h001) << 1);

  // a negative release level can never be undercut
  always_comb
  begin
    sh_under = (sh_thr > sh_hy);
    for (int i = 0; i < 3; i++)
    begin
      sh_over[i] = inten1_reg[i] & (11'(mag[i]) > sh_thr);
      if (inten1_reg[i] && 11'(mag[i]) >= 11'(sh_thr - sh_hy))
        sh_under = 1'b0;
    end
  end
  assign sh_first = sh_over & 3'(-sh_over);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_cond_reg <= 1'b0;
      rel_cond_reg <= 1'b0;
      sh_ms_reg <= 11'h000;
      rel_ms_reg <= 11'h000;
    end
    else
    begin
      if (sample_valid)
      begin
        sh_cond_reg <= |sh_over;
        rel_cond_reg <= sh_under;
      end
      // ticks on a sample edge are kept; only a broken condition restarts
      if (sample_valid && ~|sh_over)
        sh_ms_reg <= 11'h000;
      else if (ms_tick && sh_cond_reg && sh_ms_reg != 11'h7FF)
        sh_ms_reg <= sh_ms_reg + 11'h001;
      if (sample_valid && !sh_under)
        rel_ms_reg <= 11'h000;
      else if (ms_tick && rel_cond_reg && rel_ms_reg != 11'h7FF)
        rel_ms_reg <= rel_ms_reg + 11'h001;
    end
  end

  assign sh_gen = sample_valid & ~shock_int_reg & (|sh_over) & (sh_ms_reg >= sh_target);
  assign sh_drop = sample_valid & ~latch_reg & sh_under & (rel_ms_reg >= sh_target);

  // axis flags live and die with the status bit
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shock_int_reg <= 1'b0;
      first_reg <= 3'h0;
      sign_reg <= 1'b0;
    end
    else if (sh_gen)
    begin
      shock_int_reg <= 1'b1;
      first_reg <= sh_first;
      sign_reg <= sh_first[0] ? acc_x[9] : (sh_first[1] ? acc_y[9] : acc_z[9]);
    end
    else if (sh_drop || rst_int_go)
    begin
      shock_int_reg <= 1'b0;
      first_reg <= 3'h0;
      sign_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking mevd_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  flat_value_a: assert property ($rose(flat_int_reg) |-> flat_state_reg == $past(flat_now))
    else $error("flat state not taken from tilt test");
  flat_enable_a: assert property ($rose(flat_int_reg) |-> $past(inten0_reg[7]))
    else $error("flat event while disabled");
  flat_hold_a: assert property ($changed(flat_state_reg) |-> flat_int_reg)
    else $error("flat state changed without event");
  flat_pulse_a: assert property (flat_int_reg && !latch_reg && sample_valid |=> !flat_int_reg)
    else $error("flat event outlived one sample");
  ff_raise_a: assert property ($rose(ff_int_reg) |-> $past(ff_below) && $past(ff_ms_reg) >= $past(ff_target))
    else $error("free-fall raised early");
  ff_drop_a: assert property (ff_int_reg && !latch_reg && sample_valid && ff_above && !rst_int_go |=> !ff_int_reg)
    else $error("free-fall not dropped");
  shock_raise_a: assert property ($rose(shock_int_reg) |-> $past(|sh_over) && $past(sh_ms_reg) >= $past(sh_target))
    else $error("shock raised without cause");
  shock_axis_a: assert property (shock_int_reg |-> $onehot(first_reg))
    else $error("first-axis flags not one-hot");
  shock_clear_a: assert property (!shock_int_reg |-> first_reg == 3'h0)
    else $error("axis flags survive status clear");
  ro_read_a: assert property (avs_read && !ack_reg && avs_address == mevd_pkg::A_SOFTRST |=> avs_readdata == 32'h00000000)
    else $error("action register read non-zero");
  bus_wait_a: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");

  flat_event_c: cover property ($rose(flat_int_reg));
  ff_event_c: cover property ($rose(ff_int_reg));
  shock_event_c: cover property ($rose(shock_int_reg) ##[1:300] $fell(shock_int_reg));
  latch_clear_c: cover property (latch_reg && rst_int_go && shock_int_reg);
endmodule // mevd_top

/* dv/mevd_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// host model on the register bus
// ----------------------------------------
module mevd_host (
  input wire logic mclk,
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  int hangs = 0;
  // bus idle from time zero
  initial
  begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
  end
  // one access; request held until waitrequest is seen low
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] d,
    input logic [3:0] be, output logic [7:0] q);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    n = 0;
    // waitrequest judged at each rising edge; the edge that sees it low takes the access
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      hangs++;
    q = avs_readdata[7:0];
    // released right after the taking edge, a later release would open a second access
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, a, d, 4'hF, q);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    xfer(1'b1, a, 8'h00, 4'hF, q);
  endtask
  // flat limit clipped to the tilt limit, a larger one is not supported
  task automatic flat_cfg(input logic [5:0] tilt, input logic [5:0] lim);
    wr(mevd_pkg::A_TILT, {2'b00, tilt});
    wr(mevd_pkg::A_FLAT_TH, {2'b00, (lim > tilt) ? tilt : lim});
  endtask
endmodule // mevd_host

/* dv/tb_motion_event_detectors.sv */
`timescale 1ns/1ps
// ----------------------------------------
// bench for the motion event detectors
// ----------------------------------------
module tb_motion_event_detectors;
  localparam int MSC = 10;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic sample_valid = 1'b0;
  logic [9:0] acc_x = 10'h000, acc_y = 10'h000, acc_z = 10'h000;
  logic [9:0] ax = 10'h12C, ay = 10'h12C, az = 10'h12C;
  logic [7:0] q;
  int gap = 2;
  int cnt = 0;
  int n_mismatch = 0;
  int check_count = 0;
  always #50 mclk = ~mclk;
  mevd_top #(.MS_CYCLES(MSC)) dut_u (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_valid(sample_valid), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z));
  mevd_host host_u (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  // sample source, one pulse every gap cycles
  always @(posedge mclk)
  begin
    cnt <= (cnt + 1 >= gap) ? 0 : cnt + 1;
    sample_valid <= (cnt == 0);
    acc_x <= ax;
    acc_y <= ay;
    acc_z <= az;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic results;
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    host_u.rd(a, q);
    check_count++;
    if ((q & m) !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t reg %h got %h want %h", $time, a, q & m, e);
    end
  endtask
  task automatic set(input int x, input int y, input int z);
    ax <= 10'(x);
    ay <= 10'(y);
    az <= 10'(z);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // returns at the edge that carried a sample
  task automatic smp;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (sample_valid !== 1'b1 && n < 100);
    if (n >= 100)
      host_u.hangs++;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [7:0] d;
    rdchk(6'h26, 8'hFF, 8'h00);
    host_u.wr(6'h22, 8'hA5);
    rdchk(6'h22, 8'hFF, 8'hA5);
    host_u.xfer(1'b0, 6'h23, 8'h5A, 4'h0, d);
    rdchk(6'h23, 8'hFF, 8'h00);
    host_u.wr(6'h09, 8'hFF);
    rdchk(6'h09, 8'hFF, 8'h00);
    host_u.wr(6'h2D, 8'hFF);
    rdchk(6'h2D, 8'hFF, 8'h3F);
    host_u.wr(6'h21, 8'h81);
    rdchk(6'h21, 8'h81, 8'h01);
    rdchk(6'h3F, 8'hFF, 8'h00);
    host_u.wr(6'h14, 8'hB6);
    rdchk(6'h14, 8'hFF, 8'h00);
    rdchk(6'h22, 8'hFF, 8'h00);
  endtask
  task automatic t_ff;
    host_u.wr(6'h23, 8'h08);
    host_u.wr(6'h22, 8'h03);
    host_u.wr(6'h17, 8'h08);
    set(6, 6, 6);
    wt(60);
    rdchk(6'h09, 8'h01, 8'h00);
    wt(35);
    rdchk(6'h09, 8'h01, 8'h01);
    set(17, 0, 0);
    wt(10);
    rdchk(6'h09, 8'h01, 8'h00);
    // 10 counts at 4g range are 20 in 2g units, above the limit
    host_u.wr(6'h0F, 8'h01);
    set(10, 10, 10);
    wt(100);
    rdchk(6'h09, 8'h01, 8'h00);
    host_u.wr(6'h0F, 8'h00);
    wt(100);
    rdchk(6'h09, 8'h01, 8'h01);
    host_u.wr(6'h24, 8'h01);
    set(40, 0, 0);
    wt(10);
    rdchk(6'h09, 8'h01, 8'h01);
    set(0, 0, -50);
    wt(10);
    rdchk(6'h09, 8'h01, 8'h00);
    host_u.wr(6'h24, 8'h04);
    set(6, 6, 6);
    wt(100);
    rdchk(6'h09, 8'h01, 8'h00);
    set(4, 4, 4);
    wt(100);
    rdchk(6'h09, 8'h01, 8'h01);
    set(300, 300, 300);
    host_u.wr(6'h17, 8'h00);
  endtask
  task automatic t_sh;
    host_u.wr(6'h26, 8'h08);
    host_u.wr(6'h25, 8'h01);
    host_u.wr(6'h17, 8'h02);
    set(300, 0, 0);
    wt(100);
    rdchk(6'h09, 8'h02, 8'h00);
    set(0, -20, 0);
    wt(20);
    rdchk(6'h09, 8'h02, 8'h00);
    wt(45);
    rdchk(6'h09, 8'h02, 8'h02);
    rdchk(6'h0C, 8'h0F, 8'h0A);
    set(0, 0, 0);
    wt(20);
    rdchk(6'h09, 8'h02, 8'h02);
    wt(45);
    rdchk(6'h09, 8'h02, 8'h00);
    rdchk(6'h0C, 8'h07, 8'h00);
    // threshold 64, hysteresis 32: release only below 32
    host_u.wr(6'h24, 8'h40);
    host_u.wr(6'h26, 8'h20);
    set(0, 70, 0);
    wt(70);
    rdchk(6'h0C, 8'h0F, 8'h02);
    set(0, 40, 0);
    wt(70);
    rdchk(6'h09, 8'h02, 8'h02);
    set(0, 20, 0);
    wt(70);
    rdchk(6'h09, 8'h02, 8'h00);
    host_u.wr(6'h17, 8'h00);
  endtask
  task automatic t_flat;
    int t;
    gap <= 40;
    host_u.flat_cfg(6'h20, 6'h10);
    set(0, 0, 200);
    host_u.wr(6'h16, 8'h80);
    smp;
    rdchk(6'h09, 8'h80, 8'h80);
    rdchk(6'h0C, 8'h80, 8'h80);
    smp;
    rdchk(6'h09, 8'h80, 8'h00);
    host_u.wr(6'h16, 8'h00);
    set(300, 0, 100);
    smp;
    smp;
    rdchk(6'h0C, 8'h80, 8'h80);
    // settle codes 1 to 3 in turn, state flipped every pass
    for (int s = 1; s < 4; s++)
    begin
      host_u.wr(6'h2F, 8'(s << 4));
      host_u.wr(6'h16, 8'h80);
      if (s == 2)
        set(0, 0, 200);
      else if (s == 3)
        set(300, 0, 100);
      t = 512 << (s - 1);
      wt((t - 60) * MSC);
      rdchk(6'h0C, 8'h80, (s == 2) ? 8'h00 : 8'h80);
      wt(120 * MSC);
      rdchk(6'h0C, 8'h80, (s == 2) ? 8'h80 : 8'h00);
    end
    host_u.wr(6'h2F, 8'h00);
    host_u.wr(6'h21, 8'h01);
    set(0, 0, 200);
    smp;
    smp;
    smp;
    rdchk(6'h09, 8'h80, 8'h80);
    set(300, 0, 100);
    smp;
    smp;
    rdchk(6'h0C, 8'h80, 8'h80);
    // back to flat before the clear, so no change is pending when it lands
    set(0, 0, 200);
    smp;
    smp;
    host_u.wr(6'h21, 8'h81);
    rdchk(6'h09, 8'h80, 8'h00);
    set(300, 0, 100);
    smp;
    smp;
    rdchk(6'h0C, 8'h80, 8'h00);
  endtask
  // hang guards
  always @(posedge mclk)
    if (host_u.hangs != 0)
    begin
      n_mismatch++;
      results;
    end
  initial
  begin
    #8000000;
    n_mismatch++;
    results;
  end
  // main sequence
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs;
    t_ff;
    t_sh;
    t_flat;
    results;
  end
endmodule // tb_motion_event_detectors
